/* tiu_table_interp.sv */
// Table lookup and interpolation datapath with operand fetch sequencer
// Functional notes
// - The byte lookup treats entries as 8-bit values and yields 8 bits.
// - The word lookup treats entries as 16-bit values and yields 16 bits.
// - Start value is at the effective address, end value right after.
// - The fraction is unsigned 8-bit, splitting a segment in 256 steps.
// - Signed end minus start is multiplied by the fraction.
// - The result is the start value plus the signed scaled delta.
`default_nettype none
module tiu_table_interp (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Instruction request from the core
   input wire logic start,
   input wire logic is_word,
   input wire logic [15:0] eff_addr,
   input wire logic [7:0] fraction,
   // Operand fetch over the core data path
   output logic mem_req,
   output logic [15:0] mem_addr,
   output logic mem_word,
   input wire logic mem_valid,
   input wire logic [15:0] mem_rdata,
   // Results to the accumulator file
   output logic busy,
   output logic done,
   output logic result_is_word,
   output logic [7:0] result_byte,
   output logic [15:0] result_word
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      // Sequencer and fetch port
      tiu_pkg::tiu_state_t state;
      logic mem_req;
      logic [15:0] mem_addr;
      // Command taken at the accept edge
      logic is_word;
      logic [7:0] frac;
      // Fetched segment end points
      logic [15:0] start_val;
      logic [15:0] end_val;
      // Handshakes
      logic go;
      logic busy;
      logic done;
      // Result accumulators
      logic [7:0] res_byte;
      logic [15:0] res_word;
   } tiu_top_state_t;

   tiu_top_state_t s_q;
   tiu_top_state_t s_d;
   logic [15:0] rdata_sized;
   logic [15:0] next_addr;
   logic [7:0] res_byte_next;
   logic [15:0] res_word_next;
   logic accept;
   logic fetch_ack;

   // ----------------------------------------------------------------
   // Interpolation arithmetic
   // ----------------------------------------------------------------
   tiu_calc_if cif ();

   tiu_interp_calc u_calc (
      .clock(clock),
      .reset(reset),
      .cif(cif)
   );

   assign cif.go = s_q.go;
   assign cif.is_word = s_q.is_word;
   assign cif.start_val = s_q.start_val;
   assign cif.end_val = s_q.end_val;
   assign cif.frac = s_q.frac;

   // ----------------------------------------------------------------
   // Fetch handshake
   // ----------------------------------------------------------------
   // A lookup is only taken while the sequencer is idle
   assign accept = start && (s_q.state == tiu_pkg::ST_IDLE);
   // A stray data strobe outside a fetch must not advance the sequencer
   assign fetch_ack = mem_valid && s_q.mem_req;

   // ----------------------------------------------------------------
   // Operand lanes
   // ----------------------------------------------------------------
   always_comb begin
      // Byte fetch uses only the low lane of the data path
      if (s_q.is_word) begin
         rdata_sized = mem_rdata;
      end else begin
         rdata_sized = {8'h00, mem_rdata[7:0]};
      end
      // End point is one entry above; a table may not cross the top
      // of the address space, the fetch address simply wraps there
      if (s_q.is_word) begin
         next_addr = s_q.mem_addr + tiu_pkg::WORD_STEP;
      end else begin
         next_addr = s_q.mem_addr + tiu_pkg::BYTE_STEP;
      end
   end

   // ----------------------------------------------------------------
   // Result steering
   // ----------------------------------------------------------------
   always_comb begin
      // Each variant only overwrites its own accumulator
      res_byte_next = s_q.res_byte;
      res_word_next = s_q.res_word;
      if (s_q.is_word) begin
         res_word_next = cif.result;
      end else begin
         res_byte_next = cif.result[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.go = 1'b0;
      s_d.done = 1'b0;

      case (s_q.state)
         tiu_pkg::ST_IDLE: begin
            // Requests while busy are ignored, not queued
            if (accept) begin
               s_d.state = tiu_pkg::ST_FETCH_START;
               s_d.is_word = is_word;
               s_d.frac = fraction;
               s_d.mem_req = 1'b1;
               s_d.mem_addr = eff_addr;
               s_d.busy = 1'b1;
            end
         end

         tiu_pkg::ST_FETCH_START: begin
            // Start point comes back first
            if (fetch_ack) begin
               s_d.start_val = rdata_sized;
               s_d.state = tiu_pkg::ST_FETCH_END;
               s_d.mem_addr = next_addr;
            end
         end

         tiu_pkg::ST_FETCH_END: begin
            // End point closes the fetch and launches the arithmetic
            if (fetch_ack) begin
               s_d.end_val = rdata_sized;
               s_d.mem_req = 1'b0;
               s_d.go = 1'b1;
               s_d.state = tiu_pkg::ST_CALC;
            end
         end

         tiu_pkg::ST_CALC: begin
            // Arithmetic registers its result in this cycle
            s_d.state = tiu_pkg::ST_WAIT;
         end

         tiu_pkg::ST_WAIT: begin
            // Result lands in the accumulator of its own variant
            if (cif.valid) begin
               s_d.res_word = res_word_next;
               s_d.res_byte = res_byte_next;
               s_d.done = 1'b1;
               s_d.busy = 1'b0;
               s_d.state = tiu_pkg::ST_IDLE;
            end
         end

         default: begin
            s_d.state = tiu_pkg::ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Reset only loads constants; its release must be clock-aligned
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s_q <= '{state: tiu_pkg::ST_IDLE,
                  mem_req: 1'b0,
                  mem_addr: tiu_pkg::RESET_WORD,
                  is_word: 1'b0,
                  frac: tiu_pkg::RESET_BYTE,
                  start_val: tiu_pkg::RESET_WORD,
                  end_val: tiu_pkg::RESET_WORD,
                  go: 1'b0,
                  busy: 1'b0,
                  done: 1'b0,
                  res_byte: tiu_pkg::RESET_BYTE,
                  res_word: tiu_pkg::RESET_WORD};
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign mem_req = s_q.mem_req;
   assign mem_addr = s_q.mem_addr;
   assign mem_word = s_q.is_word;
   assign busy = s_q.busy;
   assign done = s_q.done;
   assign result_is_word = s_q.is_word;
   // Each accumulator holds until the next lookup of its own variant
   assign result_byte = s_q.res_byte;
   assign result_word = s_q.res_word;
endmodule
`default_nettype wire

/* tiu_pkg.sv */
// Shared constants and types of the table interpolation unit
`default_nettype none
package tiu_pkg;
   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int FRAC_W = 8;
   // ----------------------------------------------------------------
   // Arithmetic constants
   // ----------------------------------------------------------------
   // Half of one result LSB (prod carries 8 fraction bits below it), used for rounding
   localparam logic signed [25:0] ROUND_HALF = 26'sh080;
   // Distance from the start point to the end point of a segment
   localparam logic [15:0] BYTE_STEP = 16'h0001;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FETCH_START,
      ST_FETCH_END,
      ST_CALC,
      ST_WAIT
   } tiu_state_t;
endpackage
`default_nettype wire

/* tiu_calc_if.sv */
// Carrier between the sequencer and the interpolation arithmetic
`default_nettype none
interface tiu_calc_if;
   logic go;
   logic is_word;
   logic [15:0] start_val;
   logic [15:0] end_val;
   logic [7:0] frac;
   logic valid;
   logic [15:0] result;
   modport seq (output go, is_word, start_val, end_val, frac,
                input valid, result);
   modport calc (input go, is_word, start_val, end_val, frac,
                 output valid, result);
endinterface
`default_nettype wire

/* tiu_interp_calc.sv */
// Interpolation arithmetic: signed delta, scaling by fraction, sum
`default_nettype none
module tiu_interp_calc (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Operands and result
   tiu_calc_if.calc cif
);
   typedef struct packed {
      logic valid;
      logic [15:0] result;
   } tiu_calc_state_t;

   tiu_calc_state_t s_q;
   tiu_calc_state_t s_d;
   logic signed [16:0] diff;
   logic signed [25:0] prod;
   logic signed [25:0] rnd;
   logic [15:0] sum;
   logic [15:0] wdiff;
   logic [7:0] bdiff;

   always_comb begin
      // Difference wraps to the entry width and is read as signed, so
      // a step larger than half the range turns round
      wdiff = cif.end_val - cif.start_val;
      bdiff = cif.end_val[7:0] - cif.start_val[7:0];
      if (cif.is_word) begin
         diff = $signed({wdiff[15], wdiff});
      end else begin
         diff = $signed({{9{bdiff[7]}}, bdiff});
      end
      // Fraction is unsigned, radix point above bit 7
      prod = diff * $signed({1'b0, cif.frac});
      rnd = prod + tiu_pkg::ROUND_HALF;
      sum = cif.start_val + rnd[23:8];
      s_d = s_q;
      s_d.valid = cif.go;
      if (cif.go) begin
         if (cif.is_word) begin
            s_d.result = sum;
         end else begin
            s_d.result = {8'h00, sum[7:0]};
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s_q <= '{valid: 1'b0, result: tiu_pkg::RESET_WORD};
      end else begin
         s_q <= s_d;
      end
   end

   assign cif.valid = s_q.valid;
   assign cif.result = s_q.result;
endmodule
`default_nettype wire

/* tiu_monitor.sv */
// Port checker of the table interpolation unit
`default_nettype none
module tiu_monitor (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Request and fetch
   input wire logic start,
   input wire logic is_word,
   input wire logic [15:0] eff_addr,
   input wire logic mem_req,
   input wire logic [15:0] mem_addr,
   input wire logic mem_word,
   // Results
   input wire logic busy,
   input wire logic done,
   input wire logic result_is_word,
   input wire logic [7:0] result_byte,
   input wire logic [15:0] result_word
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   fetch_start_a: assert property (start && !busy |=> mem_req
      && mem_addr == $past(eff_addr) && mem_word == $past(is_word))
      else $error("first fetch wrong");
   next_point_a: assert property (mem_req && $past(mem_req)
      && mem_addr != $past(mem_addr) |-> mem_addr - $past(mem_addr)
      == (mem_word ? 16'h0002 : 16'h0001)) else $error("end fetch wrong");
   end_to_done_a: assert property ($fell(mem_req) |->
      ##2 done && !busy) else $error("done late");
   done_pulse_a: assert property (done |=> !done)
      else $error("done too long");
   word_kept_a: assert property (done && !result_is_word
      |-> $stable(result_word)) else $error("word result changed");
   byte_kept_a: assert property (done && result_is_word
      |-> $stable(result_byte)) else $error("byte result changed");
   idle_kept_a: assert property (!done |-> $stable(result_byte)
      && $stable(result_word)) else $error("result moved");
   variant_held_a: assert property (busy |=>
      $stable(result_is_word)) else $error("variant changed");
endmodule
bind tiu_table_interp tiu_monitor tiu_monitor_i (.clock(clock),
   .reset(reset), .start(start), .is_word(is_word),
   .eff_addr(eff_addr), .mem_req(mem_req), .mem_addr(mem_addr),
   .mem_word(mem_word), .busy(busy), .done(done),
   .result_is_word(result_is_word), .result_byte(result_byte),
   .result_word(result_word));
`default_nettype wire

/* tiu_mem_model.sv */
// Operand memory standing for the core data path
`default_nettype none
module tiu_mem_model (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Fetch port
   input wire logic mem_req,
   input wire logic [15:0] mem_addr,
   input wire logic mem_word,
   output logic mem_valid,
   output logic [15:0] mem_rdata,
   // Wait cycles before each answer
   input wire logic [1:0] wait_cyc
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [256];
   logic [1:0] cnt;
   logic [7:0] a;
   logic hit;
   assign a = mem_addr[7:0];
   assign hit = mem_req && !mem_valid && cnt == wait_cyc;
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         mem_valid <= 1'b0;
         cnt <= 2'h0;
         mem_rdata <= 16'h0000;
      end else begin
         mem_valid <= hit;
         cnt <= (!mem_req || mem_valid || hit) ? 2'h0 : cnt + 2'h1;
         // Words are big-endian; idle data toggles so no stale match
         if (hit)
            mem_rdata <= mem_word ? {mem[a], mem[a + 8'h01]}
               : {~mem_rdata[15:8], mem[a]};
         else
            mem_rdata <= ~mem_rdata;
      end
   end
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench of the table interpolation unit
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0, reset = 1'b1, start = 1'b0, is_word = 1'b0;
   logic [15:0] eff_addr = 16'h0000, mem_addr, mem_rdata, result_word;
   logic [7:0] fraction = 8'h00, result_byte;
   logic [1:0] wait_cyc = 2'h0;
   logic mem_req, mem_word, mem_valid, busy, done, result_is_word;
   int fails = 0, tests_run = 0;
   logic [127:0] byte_table_lookup = 128'h208010ff007f1234f0000100ffff0000;
   always #20 clock = ~clock;
   tiu_table_interp tiu_table_interp_i (.clock(clock), .reset(reset),
      .start(start), .is_word(is_word), .eff_addr(eff_addr),
      .fraction(fraction), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_word(mem_word), .mem_valid(mem_valid), .mem_rdata(mem_rdata),
      .busy(busy), .done(done), .result_is_word(result_is_word),
      .result_byte(result_byte), .result_word(result_word));
   tiu_mem_model tiu_mem_model_i (.clock(clock), .reset(reset),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_word(mem_word),
      .mem_valid(mem_valid), .mem_rdata(mem_rdata), .wait_cyc(wait_cyc));
   function automatic logic [7:0] tb_byte(int a);
      return byte_table_lookup[127 - 8 * (a - 16) -: 8];
   endfunction
   // Difference taken as a signed byte or word, delta rounded half up
   function automatic logic [15:0] interp(logic w, logic [15:0] s, e,
      logic [7:0] f);
      logic signed [26:0] p;
      logic [15:0] d;
      d = e - s;
      if (!w)
         d = {{8{d[7]}}, d[7:0]};
      p = $signed({{11{d[15]}}, d}) * $signed({19'h0, f}) + 27'sh80;
      p = (p >>> 8) + $signed({11'h0, s});
      return w ? p[15:0] : {8'h00, p[7:0]};
   endfunction
   task check(string name, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task wait_done;
      for (int i = 0; i < 60 && done !== 1'b1; i++)
         @(negedge clock);
      check("done", 16'h0001, {15'h0000, done});
   endtask
   task run_op(logic w, int a, logic [7:0] f);
      @(posedge clock);
      start <= 1'b1;
      is_word <= w;
      eff_addr <= a[15:0];
      fraction <= f;
      @(posedge clock);
      start <= 1'b0;
      @(negedge clock);
      wait_done();
      if (w)
         check("word", interp(1'b1, {tb_byte(a), tb_byte(a + 1)},
            {tb_byte(a + 2), tb_byte(a + 3)}, f), result_word);
      else
         check("byte", interp(1'b0, {8'h00, tb_byte(a)},
            {8'h00, tb_byte(a + 1)}, f), {8'h00, result_byte});
      check("variant", {15'h0000, w}, {15'h0000, result_is_word});
   endtask
   task t_byte;
      for (int i = 0; i < 4; i++)
         run_op(1'b0, 16 + i, 8'h00 + 8'h3f * i[7:0]);
      $display("byte lookups done");
   endtask
   task t_word;
      for (int i = 0; i < 4; i++)
         run_op(1'b1, 22 + 2 * i, 8'hff - 8'h55 * i[7:0]);
      $display("word lookups done");
   endtask
   task t_refuse;
      logic [15:0] held;
      int extra;
      held = result_word;
      extra = 0;
      wait_cyc <= 2'h3;
      run_op(1'b0, 17, 8'hc0);
      check("held", held, result_word);
      wait_cyc <= 2'h2;
      @(posedge clock);
      start <= 1'b1;
      is_word <= 1'b0;
      eff_addr <= 16'h0010;
      fraction <= 8'h80;
      @(posedge clock);
      start <= 1'b0;
      repeat (3) @(posedge clock);
      start <= 1'b1;
      eff_addr <= 16'h0012;
      @(posedge clock);
      start <= 1'b0;
      wait_done();
      check("busy", 16'h0050, {8'h00, result_byte});
      repeat (8) @(negedge clock) extra += int'(done === 1'b1);
      check("extra", 16'h0000, extra[15:0]);
      $display("slow and busy done");
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 16; i++)
         tiu_mem_model_i.mem[16 + i] = tb_byte(16 + i);
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      t_byte();
      t_word();
      t_refuse();
      complete_run();
   end
   initial begin
      #100000;
      fails++;
      complete_run();
   end
endmodule
`default_nettype wire
